// ### hw/bcp_pkg.sv
// Package: register map, field positions and reset values for the buffered compare timer
package bcp_pkg;
   // Register offsets (byte-wide registers, 8-bit data bus)
   localparam logic [4:0] BCP_STAT = 5'h00;  // Status and control: stop, reset, overflow flag, irq enable
   localparam logic [4:0] BCP_CNTH = 5'h01;
   localparam logic [4:0] BCP_CNTL = 5'h02;
   localparam logic [4:0] BCP_MODH = 5'h03;
   localparam logic [4:0] BCP_MODL = 5'h04;
   localparam logic [4:0] BCP_SC0 = 5'h05;  // Channel n control at BCP_SC0 + 3n
   localparam logic [4:0] BCP_CHH0 = 5'h06;  // Channel n value high at BCP_CHH0 + 3n
   localparam logic [4:0] BCP_CHL0 = 5'h07;  // Channel n value low at BCP_CHL0 + 3n
   localparam logic [4:0] BCP_CH_STRIDE = 5'h03;
   localparam logic [4:0] BCP_GPIO = 5'h11;  // Released pin control: [1], [3] levels, [2] shared oe
   // Global status and control fields
   localparam int BCP_STAT_OVF = 7;
   localparam int BCP_STAT_OIE = 6;
   localparam int BCP_STAT_STOP = 5;
   localparam int BCP_STAT_RST = 4;
   // Channel control fields
   localparam int BCP_CH_FLAG = 7;
   localparam int BCP_CH_IE = 6;
   localparam int BCP_CH_MSB = 5;
   localparam int BCP_CH_MSA = 4;
   localparam int BCP_CH_ELSB = 3;
   localparam int BCP_CH_ELSA = 2;
   localparam int BCP_CH_TOV = 1;
   localparam int BCP_CH_MAX = 0;
   // Reset values
   localparam logic [15:0] BCP_MOD_RST = 16'hffff;
   localparam logic [7:0] BCP_SC_RST = 8'h00;
   localparam logic [15:0] BCP_CNT_RST = 16'h0000;
   localparam logic [7:0] BCP_RD_UNMAPPED = 8'h00;
   localparam int BCP_NCH = 4;
endpackage : bcp_pkg

// ### hw/bcp_counter.sv
// Shared free-running counter with modulo rollover
`timescale 1ns/1ps
`default_nettype none
module bcp_counter (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic stop,
   input wire logic clear,
   input wire logic [15:0] modulo,
   output logic [15:0] count,
   output logic overflow
);
   import bcp_pkg::*;
   logic [15:0] count_q;
   logic [15:0] count_d;
   logic at_mod;

   // Rollover to zero once the modulo value has been reached
   assign at_mod = (count_q == modulo);
   assign overflow = at_mod && !stop && !clear;
   assign count_d = clear ? BCP_CNT_RST : (stop ? count_q : (at_mod ? BCP_CNT_RST : count_q + 16'h0001));
   assign count = count_q;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         count_q <= BCP_CNT_RST;
      end else begin
         count_q <= count_d;
      end
   end
endmodule : bcp_counter
`default_nettype wire

// ### hw/bcp_pair.sv
// Active-set selector for one linked channel pair
`timescale 1ns/1ps
`default_nettype none
module bcp_pair (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic linked,
   input wire logic wr_even,
   input wire logic wr_odd,
   input wire logic overflow,
   output logic sel_odd
);
   import bcp_pkg::*;
   logic last_odd_q;
   logic last_odd_d;
   logic sel_q;
   logic sel_d;
   logic linked_q;

   // Remember the set written last; odd write wins if both in one cycle
   assign last_odd_d = (!linked || !linked_q) ? 1'b0 : (wr_odd ? 1'b1 : (wr_even ? 1'b0 : last_odd_q));
   // Take over only at overflow; unlinked or fresh link starts on even
   assign sel_d = (!linked || !linked_q) ? 1'b0 : (overflow ? last_odd_d : sel_q);
   assign sel_odd = sel_q;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         last_odd_q <= 1'b0;
         sel_q <= 1'b0;
         linked_q <= 1'b0;
      end else begin
         last_odd_q <= last_odd_d;
         sel_q <= sel_d;
         linked_q <= linked;
      end
   end
endmodule : bcp_pair
`default_nettype wire

// ### hw/bcp_timer.sv
// Four-channel buffered output compare and PWM timer, top level
// How it works
// - Pair-A link bit in channel 0 control merges channels 0 and 1 onto pin 0.
// - Just after linking, channel 0 compare value drives the linked pin.
// - Write to the inactive partner hands it the output at next overflow.
// - Each later overflow selects the most recently written set of the pair.
// - While linked, the even control register controls and reports the pair.
// - Pair A linked: channel 1 control ignored, pin 1 released as GPIO.
// - Pair-B link bit merges channels 2 and 3 onto pin 2, channel 2 first.
// - Pair B linked: channel 3 control ignored, pin 3 released as GPIO.
// - With toggle-on-overflow, pin toggles when counter rolls over from the modulo value to zero.
// - Pulse width is time from overflow to the channel compare match.
// - Modulo 255 undivided gives a 256-clock period, 8-bit resolution.
// - Compare value 128 in a 256 period gives 50 percent duty.
// - Unsynchronised unbuffered overwrite may miss a compare for up to one period.
// - Compare interrupt at pulse end, overflow interrupt at period end.
// - Toggle-on-overflow clear suppresses overflow toggles; with clear on compare this gives 0 percent duty.
// - Max-duty set with toggle-on-overflow clear gives 100 percent duty.
// - Compare match sets channel flag; interrupt only when its enable is 1.
//
// Chosen here: the register addresses and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module bcp_timer (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [4:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [7:0] rdata,
   input wire logic [3:0] pin_in,
   output logic [3:0] pin_out,
   output logic [3:0] pin_oe,
   output logic ovf_irq,
   output logic [3:0] ch_irq
);
   import bcp_pkg::*;

   // Register state
   logic [7:0] stat_q;
   logic [15:0] mod_q;
   logic [7:0] sc_q [BCP_NCH];
   logic [15:0] chv_q [BCP_NCH];
   logic [7:0] wlatch_q;  // Byte of the last write of any register, used as the high byte when a low byte completes the word
   logic [7:0] rlatch_q;  // Counter low byte frozen by a high-byte read
   logic [3:0] gpio_q;
   logic [3:0] pin_q;
   logic [3:0] oe_q;
   logic [7:0] rdata_q;
   logic ovf_irq_q;
   logic [3:0] ch_irq_q;
   logic [3:0] flag_armed_q;   // Flag read while set, so a zero write may clear it
   logic ovf_armed_q;

   // Counter and pair selectors
   logic [15:0] count;
   logic overflow;
   logic sel_a_odd;
   logic sel_b_odd;
   logic link_a;
   logic link_b;

   // Address decode
   function automatic logic is_ch_reg(input logic [4:0] a, input logic [4:0] base, input int n);
      is_ch_reg = (a == 5'(base + 5'(n) * BCP_CH_STRIDE));
   endfunction : is_ch_reg

   // Buffered mode takes priority over unbuffered on an even channel
   function automatic logic even_on(input logic [7:0] sc);
      even_on = sc[BCP_CH_MSB] || sc[BCP_CH_MSA];
   endfunction : even_on

   // Active register set of a linked pair; an unlinked even channel keeps its own value
   function automatic logic [15:0] pick_set(input logic linked, input logic odd, input logic [15:0] even_v,
      input logic [15:0] odd_v);
      pick_set = (linked && odd) ? odd_v : even_v;
   endfunction : pick_set

   logic [3:0] hit_sc;
   logic [3:0] hit_chh;
   logic [3:0] hit_chl;
   logic hit_stat;
   logic [3:0] wr_val;   // Full 16-bit value completed this cycle on channel n
   logic [3:0] match;
   logic [3:0] eff_en;   // Channel owns and drives its pin
   logic [7:0] rd_mux;
   // Fixed register decode and shared datapath terms
   logic hit_cnth;
   logic hit_cntl;
   logic hit_modh;
   logic hit_modl;
   logic hit_gpio;
   logic [15:0] wr_word;
   logic cnt_run;
   logic [15:0] cnt_next;

   for (genvar n = 0; n < BCP_NCH; n++) begin : g_dec
      assign hit_sc[n] = is_ch_reg(addr, BCP_SC0, n);
      assign hit_chh[n] = is_ch_reg(addr, BCP_CHH0, n);
      assign hit_chl[n] = is_ch_reg(addr, BCP_CHL0, n);
      assign wr_val[n] = wr && hit_chl[n];
   end
   assign hit_stat = (addr == BCP_STAT);
   assign hit_cnth = (addr == BCP_CNTH);
   assign hit_cntl = (addr == BCP_CNTL);
   assign hit_modh = (addr == BCP_MODH);
   assign hit_modl = (addr == BCP_MODL);
   assign hit_gpio = (addr == BCP_GPIO);
   // Modulo and channel values take the held high byte beside the low byte written now
   assign wr_word = {wlatch_q, wdata};

   assign link_a = sc_q[0][BCP_CH_MSB];
   assign link_b = sc_q[2][BCP_CH_MSB];

   bcp_counter u_counter (
      .clk(clk),
      .sys_rst(sys_rst),
      .stop(stat_q[BCP_STAT_STOP]),
      .clear(stat_q[BCP_STAT_RST]),
      .modulo(mod_q),
      .count(count),
      .overflow(overflow)
   );

   // Channel 0 is even: channel 1 writes mark the odd set
   bcp_pair u_pair_a (
      .clk(clk),
      .sys_rst(sys_rst),
      .linked(link_a),
      .wr_even(wr_val[0]),
      .wr_odd(wr_val[1]),
      .overflow(overflow),
      .sel_odd(sel_a_odd)
   );

   bcp_pair u_pair_b (
      .clk(clk),
      .sys_rst(sys_rst),
      .linked(link_b),
      .wr_even(wr_val[2]),
      .wr_odd(wr_val[3]),
      .overflow(overflow),
      .sel_odd(sel_b_odd)
   );

   // Compare sources: a linked even channel compares with the active set
   logic [15:0] cmp_val [BCP_NCH];
   assign cmp_val[0] = pick_set(link_a, sel_a_odd, chv_q[0], chv_q[1]);
   assign cmp_val[1] = chv_q[1];
   assign cmp_val[2] = pick_set(link_b, sel_b_odd, chv_q[2], chv_q[3]);
   assign cmp_val[3] = chv_q[3];
   assign eff_en[0] = even_on(sc_q[0]);
   assign eff_en[1] = !link_a && sc_q[1][BCP_CH_MSA];
   assign eff_en[2] = even_on(sc_q[2]);
   assign eff_en[3] = !link_b && sc_q[3][BCP_CH_MSA];

   // Value the counter takes at this edge; compares act as the counter arrives,
   // just as the overflow toggle acts at rollover, so the pulse lasts exactly the value
   assign cnt_run = !stat_q[BCP_STAT_STOP] && !stat_q[BCP_STAT_RST];
   assign cnt_next = overflow ? BCP_CNT_RST : count + 16'h0001;

   // Stopped counter gives no fresh compares; a value already passed waits a period
   for (genvar n = 0; n < BCP_NCH; n++) begin : g_match
      assign match[n] = eff_en[n] && cnt_run && (cnt_next == cmp_val[n]);
   end

   // Pin next state: overflow toggle, then compare action, then max duty
   function automatic logic pin_next(input logic cur, input logic [7:0] sc, input logic m, input logic ov);
      logic v;
      v = cur;
      if (ov && sc[BCP_CH_TOV]) begin
         v = ~cur;
      end
      // A compare on the rollover cycle acts after the toggle, so a zero value gives 0 percent
      if (m) begin
         case (sc[BCP_CH_ELSB:BCP_CH_ELSA])
            2'b01: v = ~v;
            2'b10: v = 1'b0;
            2'b11: v = 1'b1;
            default: v = v;
         endcase
      end
      if (sc[BCP_CH_MAX] && !sc[BCP_CH_TOV]) begin
         v = 1'b1;
      end
      pin_next = v;
   endfunction : pin_next

   // Read multiplexer: counter high read freezes the low byte
   always_comb begin
      rd_mux = BCP_RD_UNMAPPED;
      if (hit_stat) begin
         rd_mux = stat_q;
      end else if (hit_cnth) begin
         rd_mux = count[15:8];
      end else if (hit_cntl) begin
         rd_mux = rlatch_q;
      end else if (hit_modh) begin
         rd_mux = mod_q[15:8];
      end else if (hit_modl) begin
         rd_mux = mod_q[7:0];
      end else if (hit_gpio) begin
         rd_mux = {4'h0, gpio_q};
      end else begin
         for (int n = 0; n < BCP_NCH; n++) begin
            if (hit_sc[n]) begin
               rd_mux = sc_q[n];
            end else if (hit_chh[n]) begin
               rd_mux = chv_q[n][15:8];
            end else if (hit_chl[n]) begin
               rd_mux = chv_q[n][7:0];
            end
         end
      end
   end

   // Global status: overflow flag set wins over the two-step clear
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         stat_q <= {2'b00, 1'b1, 5'h00};
         ovf_armed_q <= 1'b0;
      end else begin
         if (wr && hit_stat) begin
            stat_q[BCP_STAT_OIE:0] <= wdata[BCP_STAT_OIE:0];  // Counter reset bit taken here too
         end else begin
            stat_q[BCP_STAT_RST] <= 1'b0;  // Counter reset is a one-shot
         end
         if (overflow) begin
            stat_q[BCP_STAT_OVF] <= 1'b1;
         end else if (wr && hit_stat && !wdata[BCP_STAT_OVF] && ovf_armed_q) begin
            stat_q[BCP_STAT_OVF] <= 1'b0;
         end
         if (rd && hit_stat && stat_q[BCP_STAT_OVF]) begin
            ovf_armed_q <= 1'b1;
         end else if (wr && hit_stat) begin
            ovf_armed_q <= 1'b0;
         end
      end
   end

   // Modulo and byte latches; every written byte is held as the high byte for the next low-byte write
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         mod_q <= BCP_MOD_RST;
         wlatch_q <= 8'h00;
         rlatch_q <= 8'h00;
         gpio_q <= 4'h0;
      end else begin
         if (wr) begin
            wlatch_q <= wdata;
         end
         if (wr && hit_modl) begin
            mod_q <= wr_word;
         end
         if (rd && hit_cnth) begin
            rlatch_q <= count[7:0];
         end
         if (wr && hit_gpio) begin
            gpio_q <= wdata[3:0];
         end
      end
   end

   // Channel registers and flags
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         for (int n = 0; n < BCP_NCH; n++) begin
            sc_q[n] <= BCP_SC_RST;
            chv_q[n] <= BCP_CNT_RST;
         end
         flag_armed_q <= 4'h0;
      end else begin
         for (int n = 0; n < BCP_NCH; n++) begin
            if (wr && hit_sc[n]) begin
               sc_q[n][BCP_CH_IE:0] <= wdata[BCP_CH_IE:0];
            end
            if (wr_val[n]) begin
               chv_q[n] <= wr_word;
            end
            // Flag clear needs a read while set, then a zero write; a match wins
            if (match[n]) begin
               sc_q[n][BCP_CH_FLAG] <= 1'b1;
            end else if (wr && hit_sc[n] && !wdata[BCP_CH_FLAG] && flag_armed_q[n]) begin
               sc_q[n][BCP_CH_FLAG] <= 1'b0;
            end
            if (rd && hit_sc[n] && sc_q[n][BCP_CH_FLAG]) begin
               flag_armed_q[n] <= 1'b1;
            end else if (wr && hit_sc[n]) begin
               flag_armed_q[n] <= 1'b0;
            end
         end
      end
   end

   // Pins, outputs and read data, all registered
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pin_q <= 4'h0;
         oe_q <= 4'h0;
         rdata_q <= 8'h00;
         ovf_irq_q <= 1'b0;
         ch_irq_q <= 4'h0;
      end else begin
         for (int n = 0; n < BCP_NCH; n++) begin
            pin_q[n] <= eff_en[n] ? pin_next(pin_q[n], sc_q[n], match[n], overflow) : gpio_q[n];
            oe_q[n] <= eff_en[n];
         end
         // Released odd pins fall back to general-purpose control
         if (link_a) begin
            pin_q[1] <= gpio_q[1];
            oe_q[1] <= gpio_q[2];
         end
         if (link_b) begin
            pin_q[3] <= gpio_q[3];
            oe_q[3] <= gpio_q[2];
         end
         rdata_q <= rd ? rd_mux : 8'h00;
         // Level interrupts follow the registered flags one cycle late
         ovf_irq_q <= stat_q[BCP_STAT_OVF] && stat_q[BCP_STAT_OIE];
         for (int n = 0; n < BCP_NCH; n++) begin
            ch_irq_q[n] <= sc_q[n][BCP_CH_FLAG] && sc_q[n][BCP_CH_IE] && eff_en[n];
         end
      end
   end

   // Unused pin inputs: capture is outside this block
   logic unused_in;
   assign unused_in = ^pin_in;

   assign rdata = rdata_q;
   assign pin_out = pin_q;
   assign pin_oe = oe_q;
   assign ovf_irq = ovf_irq_q;
   assign ch_irq = ch_irq_q;
endmodule : bcp_timer
`default_nettype wire

// ### tb/bcp_load.sv
// Load on the channel pins: resolves each pin and times pulses on pin 0
`timescale 1ns/1ps
`default_nettype none
module bcp_load (
   input wire logic clk,
   input wire logic [3:0] pin_out,
   input wire logic [3:0] pin_oe,
   output logic [3:0] pin_in,
   output logic [15:0] high_q,
   output logic [15:0] period_q
);
   logic [15:0] run_q = 16'h0000;
   logic last_q = 1'b0;
   logic rise;
   logic fall;
   // Released pins sit at the pull-down level, never at a stale value
   assign pin_in = pin_out & pin_oe;
   assign rise = pin_in[0] && !last_q;
   assign fall = !pin_in[0] && last_q;
   // Rise to fall is the pulse, rise to rise the period
   always_ff @(posedge clk) begin
      last_q <= pin_in[0];
      run_q <= rise ? 16'h0001 : run_q + 16'h0001;
      if (rise) period_q <= run_q;
      if (fall) high_q <= run_q;
   end
endmodule : bcp_load
`default_nettype wire

// ### tb/bcp_timer_asserts.sv
// Checker on the timer top-level ports
`timescale 1ns/1ps
`default_nettype none
module bcp_timer_asserts (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [4:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [7:0] rdata,
   input wire logic [3:0] pin_out,
   input wire logic [3:0] pin_oe,
   input wire logic ovf_irq,
   input wire logic [3:0] ch_irq
);
   import bcp_pkg::*;
   logic [7:0] sc0_q;
   logic [7:0] sc2_q;
   logic oie_q;
   logic wr_sc0;
   logic wr_sc2;
   logic wr_stat;
   logic full_c;
   // Write decode for the control bits mirrored here
   assign wr_sc0 = wr && (addr == BCP_SC0);
   assign wr_sc2 = wr && (addr == BCP_SC0 + BCP_CH_STRIDE + BCP_CH_STRIDE);
   assign wr_stat = wr && (addr == BCP_STAT);
   assign full_c = (sc2_q[BCP_CH_MSB] | sc2_q[BCP_CH_MSA]) & sc2_q[BCP_CH_MAX] & !sc2_q[BCP_CH_TOV];
   // Mirror of software settings; flag bits unused since hardware sets them
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         sc0_q <= BCP_SC_RST;
         sc2_q <= BCP_SC_RST;
         oie_q <= 1'b0;
      end else begin
         if (wr_sc0) sc0_q <= wdata;
         if (wr_sc2) sc2_q <= wdata;
         if (wr_stat) oie_q <= wdata[BCP_STAT_OIE];
      end
   end
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);
   rd_idle_a: assert property (!rd |=> rdata == 8'h00)
      else $error("read data not zero outside a read");
   unmapped_rd_a: assert property (rd && addr > BCP_GPIO |=> rdata == BCP_RD_UNMAPPED)
      else $error("unmapped read not zero");
   reset_out_a: assert property ($fell(sys_rst) |-> pin_out == 4'h0 && pin_oe == 4'h0 && ch_irq == 4'h0 && !ovf_irq)
      else $error("outputs not clear after reset");
   pair_a_irq_a: assert property (sc0_q[BCP_CH_MSB] && $past(sc0_q[BCP_CH_MSB]) |-> !ch_irq[1])
      else $error("channel 1 interrupt while pair A linked");
   pair_b_irq_a: assert property (sc2_q[BCP_CH_MSB] && $past(sc2_q[BCP_CH_MSB]) |-> !ch_irq[3])
      else $error("channel 3 interrupt while pair B linked");
   ovf_mask_a: assert property (!oie_q && !$past(oie_q) |-> !ovf_irq)
      else $error("overflow interrupt while disabled");
   ch0_mask_a: assert property (!sc0_q[BCP_CH_IE] && !$past(sc0_q[BCP_CH_IE]) |-> !ch_irq[0])
      else $error("channel 0 interrupt while disabled");
   full_duty_a: assert property (full_c && $past(full_c) |-> pin_out[2])
      else $error("pin 2 low under full duty");
endmodule : bcp_timer_asserts
bind bcp_timer bcp_timer_asserts u_chk (.clk(clk), .sys_rst(sys_rst), .addr(addr), .wdata(wdata), .wr(wr),
   .rd(rd), .rdata(rdata), .pin_out(pin_out), .pin_oe(pin_oe), .ovf_irq(ovf_irq), .ch_irq(ch_irq));
`default_nettype wire

// ### tb/tb_top.sv
// Testbench for the buffered compare timer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import bcp_pkg::*;
   localparam logic [4:0] sc1 = BCP_SC0 + BCP_CH_STRIDE;
   localparam logic [4:0] sc2 = sc1 + BCP_CH_STRIDE;
   localparam logic [4:0] chh1 = BCP_CHH0 + BCP_CH_STRIDE;
   logic clk, sys_rst, wr, rd, ovf_irq;
   logic [4:0] addr;
   logic [7:0] wdata, rdata, v;
   logic [3:0] pin_in, pin_out, pin_oe, ch_irq;
   logic [15:0] high_q, period_q;
   int err_count = 0;
   int check_count = 0;
   int n;
   bcp_timer dut (.clk(clk), .sys_rst(sys_rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
      .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .ovf_irq(ovf_irq), .ch_irq(ch_irq));
   bcp_load u_load (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in), .high_q(high_q),
      .period_q(period_q));
   // 50 MHz clock
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   task give_verdict;
      $display("checks %0d errors %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : give_verdict
   task chk(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_count++;
         $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task wr_reg(input logic [4:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr_reg
   // High byte first, the low byte commits the pair
   task wr16(input logic [4:0] a, input logic [15:0] d);
      wr_reg(a, d[15:8]);
      wr_reg(a + 5'h01, d[7:0]);
   endtask : wr16
   task rd_reg(input logic [4:0] a, output logic [7:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      d = rdata;
   endtask : rd_reg
   // Bounded wait for a level on pin 0, watchdog covers the rest
   task wait_lvl(input logic l);
      #1;
      for (int i = 0; i < 700 && pin_in[0] !== l; i++) begin
         @(posedge clk);
         #1;
      end
   endtask : wait_lvl
   // Full pulse of the period after the next overflow, then its period
   task measure(input logic [15:0] hi);
      wait_lvl(1'b0);
      wait_lvl(1'b1);
      wait_lvl(1'b0);
      @(posedge clk);
      #1;
      chk(high_q, hi);
      wait_lvl(1'b1);
      @(posedge clk);
      #1;
      chk(period_q, 16'd256);
   endtask : measure
   // Cycles with pin 2 high over one period
   task count_hi;
      n = 0;
      repeat (256) begin
         @(posedge clk);
         n += int'(pin_out[2] === 1'b1);
      end
   endtask : count_hi
   // Cuts a hang short
   initial begin
      repeat (40000) @(posedge clk);
      err_count++;
      give_verdict();
   end
   initial begin
      sys_rst = 1'b1;
      addr = 5'h00;
      wdata = 8'h00;
      wr = 1'b0;
      rd = 1'b0;
      repeat (8) @(posedge clk);
      sys_rst <= 1'b0;
      rd_reg(5'h1f, v);
      chk(16'(v), 16'(BCP_RD_UNMAPPED));
      rd_reg(BCP_STAT, v);
      chk(16'(v & 8'h20), 16'h0020);
      wr16(BCP_MODH, 16'h00ff);
      wr16(BCP_CHH0, 16'h0080);
      wr_reg(BCP_SC0, 8'h2a);
      wr_reg(BCP_STAT, 8'h00);
      measure(16'd128);
      wr_reg(sc1, 8'h58);
      wr_reg(BCP_GPIO, 8'h0f);
      repeat (2) @(posedge clk);
      chk(16'({pin_oe[1], pin_out[1], pin_oe[0]}), 16'h0007);
      wr16(chh1, 16'h0040);
      measure(16'd64);
      wr16(BCP_CHH0, 16'h00c0);
      measure(16'd192);
      wr16(chh1, 16'h0020);
      measure(16'd32);
      wr_reg(BCP_SC0, 8'h1a);
      wr_reg(BCP_SC0, 8'h2a);
      measure(16'd192);
      rd_reg(BCP_SC0, v);
      chk(16'(v & 8'ha0), 16'h00a0);
      wr_reg(BCP_SC0, 8'h6a);
      repeat (260) @(posedge clk);
      chk(16'(ch_irq[0]), 16'h0001);
      wr_reg(BCP_STAT, 8'h40);
      repeat (260) @(posedge clk);
      chk(16'(ovf_irq), 16'h0001);
      wr_reg(sc2, 8'h28);
      wr_reg(sc2 + BCP_CH_STRIDE, 8'h58);
      repeat (300) @(posedge clk);
      chk(16'({pin_oe[3], pin_out[3], pin_oe[2]}), 16'h0007);
      count_hi();
      chk(16'(n), 16'd0);
      wr_reg(sc2, 8'h29);
      repeat (3) @(posedge clk);
      count_hi();
      chk(16'(n), 16'd256);
      // Unbuffered channel 0: shorten after the compare, lengthen after the overflow
      wr_reg(BCP_SC0, 8'h1a);
      wait_lvl(1'b1);
      wait_lvl(1'b0);
      wr16(BCP_CHH0, 16'h0030);
      measure(16'd48);
      wait_lvl(1'b1);
      wr16(BCP_CHH0, 16'h00a0);
      measure(16'd160);
      give_verdict();
   end
endmodule : tb_top
`default_nettype wire
